// file: include/clk_out_cfg_pkg.sv
/*
 * Constants and decode helpers for the sensor reference clock configuration block.
 * Assumes an 8-bit register port at byte offsets 0x04..0x07 and a single clock domain.
 */
// Function
// - Lock autoloads raw10 mode unless blocked
// - Lock autoloads raw12 mode unless blocked
// - Block bit stops autoload of both modes
// - Reference input divided by 1,2,4,8
// - Oscillator range select when internal reference used
// - High-speed clock prescaled by 1 to 16
// - Numerator M from bits 4:0, default 1
// - Zero numerator treated as one
package clk_out_cfg_pkg;

	localparam logic [7:0] OFS_MODE_OVR = 8'h04;
	localparam logic [7:0] OFS_PLL_REF  = 8'h05;
	localparam logic [7:0] OFS_OUT_LO   = 8'h06;
	localparam logic [7:0] OFS_OUT_DEN  = 8'h07;

	localparam logic [7:0] RST_MODE_OVR = 8'h00;
	localparam logic [7:0] RST_PLL_REF  = 8'h03;
	localparam logic [7:0] RST_OUT_LO   = 8'h41;
	localparam logic [7:0] RST_OUT_DEN  = 8'h28;
	localparam logic [7:0] RDATA_NONE   = 8'h00;

	localparam int RAW10_BIT  = 2;
	localparam int RAW12_BIT  = 1;
	localparam int BLOCK_BIT  = 0;
	localparam int OSC_BIT    = 3;
	localparam int REFDIV_LSB = 4;
	localparam int PRESC_LSB  = 5;
	localparam int NUM_LSB    = 0;
	localparam int CODE_W     = 3;
	localparam int NUM_W      = 5;
	localparam int DEN_W      = 8;

	localparam logic [NUM_W-1:0]  NUM_ZERO         = 5'h00;
	localparam logic [NUM_W-1:0]  NUM_DEFAULT      = 5'h01;
	localparam logic [CODE_W-1:0] REFDIV_MAX_SHIFT = 3'h3;
	localparam logic [CODE_W-1:0] PRESC_MAX_SHIFT  = 3'h4;

	// Reserved codes clamp to the largest legal ratio
	function automatic logic [CODE_W-1:0] code_to_shift(
		input logic [CODE_W-1:0] code,
		input logic [CODE_W-1:0] max_shift
	);
		return (code > max_shift) ? max_shift : code;
	endfunction

endpackage

// file: rtl/pow2_tick_divider.sv
/*
 * Divides a one-cycle tick stream by 2**shift.
 * Assumes i_tick is a synchronous single-cycle strobe on i_mclk.
 */
`timescale 1ns/1ps
module pow2_tick_divider #(
	parameter int MAX_SHIFT = 4
) (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_b,
	input  wire logic       i_tick,
	input  wire logic [2:0] i_shift,
	output logic            o_tick
);

	localparam int CNT_W = (MAX_SHIFT < 1) ? 1 : MAX_SHIFT;

	if (MAX_SHIFT < 1 || MAX_SHIFT > 7)
		$error("pow2_tick_divider: MAX_SHIFT out of range");

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] terminal;
	logic             wrap;
	logic             tick_reg;

	assign terminal = CNT_W'((1 << i_shift) - 1);
	assign wrap     = i_tick && (cnt_reg >= terminal);
	assign cnt_next = wrap ? '0 : (i_tick ? cnt_reg + 1'b1 : cnt_reg);
	assign o_tick   = tick_reg;

	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= wrap;
		end
	end

endmodule // pow2_tick_divider

// file: rtl/frac_mn_divider.sv
/*
 * Fractional M/N divider: a toggling output at f_tick * M / N.
 * Assumes M is already nonzero and that software keeps N nonzero.
 */
`timescale 1ns/1ps
module frac_mn_divider #(
	parameter int M_W = 5,
	parameter int N_W = 8
) (
	input  wire logic           i_mclk,
	input  wire logic           i_rst_b,
	input  wire logic           i_tick,
	input  wire logic [M_W-1:0] i_num,
	input  wire logic [N_W-1:0] i_den,
	output logic                o_clk
);

	localparam int ACC_W = ((M_W > N_W) ? M_W : N_W) + 2;

	if (M_W < 1 || N_W < 2)
		$error("frac_mn_divider: widths too small");

	logic [ACC_W-1:0] acc_reg;
	logic [ACC_W-1:0] acc_next;
	logic [ACC_W-1:0] sum;
	logic             wrap;
	logic             stale;
	logic             clk_reg;

	// Two half periods per output cycle, so step by 2M
	assign sum      = acc_reg + ACC_W'({i_num, 1'b0});
	// A smaller N leaves a stale phase that would run fast for up to N ticks
	assign stale    = (acc_reg >= ACC_W'(i_den));
	assign wrap     = i_tick && (i_den != '0) && !stale && (sum >= ACC_W'(i_den));
	assign acc_next = !i_tick ? acc_reg :
	                  stale   ? '0 :
	                  wrap    ? sum - ACC_W'(i_den) : sum;
	assign o_clk    = clk_reg;

	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			acc_reg <= '0;
			clk_reg <= 1'b0;
		end
		else
		begin
			acc_reg <= acc_next;
			clk_reg <= clk_reg ^ wrap;
		end
	end

endmodule // frac_mn_divider

// file: rtl/clock_output_config.sv
/*
 * Clock output configuration: compatibility mode bits with lock autoload,
 * reference input divider and oscillator range select, and the sensor
 * reference clock generator (prescaler plus M/N fractional divider).
 * Assumes all inputs are synchronous to i_mclk; clocks of other domains
 * arrive as one-cycle ticks, and the register port is a simple
 * address/strobe port at the documented byte offsets.
 */
`timescale 1ns/1ps
module clock_output_config (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_b,

	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_rd,
	output logic      [7:0] o_reg_rdata,

	input  wire logic       i_rx_lock,
	input  wire logic       i_bc_raw10_mode,
	input  wire logic       i_bc_raw12_mode,

	input  wire logic       i_ref_clock_in_tick,
	input  wire logic       i_osc_tick,
	input  wire logic       i_nonsync_internal_mode,
	input  wire logic       i_ext_clk_detected,

	input  wire logic       i_hs_tick,

	output logic            o_raw10_compat_mode,
	output logic            o_raw12_compat_mode,
	output logic            o_compat_autoload_block,
	output logic            o_oscillator_range_select,
	output logic            o_internal_ref_select,
	output logic            o_ref_tick,
	output logic            o_sensor_ref_clock_out
);

	// Register storage

	logic [7:0] mode_ovr_reg;
	logic [7:0] mode_ovr_next;
	logic [7:0] pll_ref_reg;
	logic [7:0] pll_ref_next;
	logic [7:0] out_lo_reg;
	logic [7:0] out_lo_next;
	logic [7:0] out_den_reg;
	logic [7:0] out_den_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	logic       rx_lock_reg;
	logic       internal_ref_reg;
	logic       internal_ref_next;
	logic       ref_tick_reg;
	logic       ref_tick_next;

	// Address decode

	logic       sel_mode_ovr;
	logic       sel_pll_ref;
	logic       sel_out_lo;
	logic       sel_out_den;
	logic       wr_mode_ovr;
	logic       wr_pll_ref;
	logic       wr_out_lo;
	logic       wr_out_den;

	assign sel_mode_ovr = (i_reg_addr == clk_out_cfg_pkg::OFS_MODE_OVR);
	assign sel_pll_ref  = (i_reg_addr == clk_out_cfg_pkg::OFS_PLL_REF);
	assign sel_out_lo   = (i_reg_addr == clk_out_cfg_pkg::OFS_OUT_LO);
	assign sel_out_den  = (i_reg_addr == clk_out_cfg_pkg::OFS_OUT_DEN);

	assign wr_mode_ovr  = i_reg_wr && sel_mode_ovr;
	assign wr_pll_ref   = i_reg_wr && sel_pll_ref;
	assign wr_out_lo    = i_reg_wr && sel_out_lo;
	assign wr_out_den   = i_reg_wr && sel_out_den;

	// Compatibility mode bits and back-channel autoload

	logic       lock_rise;
	logic [7:0] mode_sw_value;
	logic       block_next;
	logic       autoload;

	assign lock_rise     = i_rx_lock && !rx_lock_reg;
	assign mode_sw_value = wr_mode_ovr ? i_reg_wdata : mode_ovr_reg;

	// A block bit written in the same cycle as lock already protects
	assign block_next    = mode_sw_value[clk_out_cfg_pkg::BLOCK_BIT];
	assign autoload      = lock_rise && !block_next;

	always_comb
	begin
		mode_ovr_next = mode_sw_value;
		if (autoload)
		begin
			// Hardware load wins over a same-cycle software write of these bits
			mode_ovr_next[clk_out_cfg_pkg::RAW10_BIT] = i_bc_raw10_mode;
			mode_ovr_next[clk_out_cfg_pkg::RAW12_BIT] = i_bc_raw12_mode;
		end
	end

	// Plain read/write registers

	assign pll_ref_next = wr_pll_ref ? i_reg_wdata : pll_ref_reg;
	assign out_lo_next  = wr_out_lo  ? i_reg_wdata : out_lo_reg;
	assign out_den_next = wr_out_den ? i_reg_wdata : out_den_reg;

	// Read data, registered; unmapped offsets read zero

	assign rdata_next = !i_reg_rd   ? rdata_reg :
	                    sel_mode_ovr ? mode_ovr_reg :
	                    sel_pll_ref  ? pll_ref_reg :
	                    sel_out_lo   ? out_lo_reg :
	                    sel_out_den  ? out_den_reg :
	                    clk_out_cfg_pkg::RDATA_NONE;

	// Field extraction

	logic [clk_out_cfg_pkg::CODE_W-1:0] refdiv_code;
	logic [clk_out_cfg_pkg::CODE_W-1:0] refdiv_shift;
	logic [clk_out_cfg_pkg::CODE_W-1:0] presc_code;
	logic [clk_out_cfg_pkg::CODE_W-1:0] presc_shift;
	logic [clk_out_cfg_pkg::NUM_W-1:0]  num_field;
	logic [clk_out_cfg_pkg::NUM_W-1:0]  num_eff;
	logic [clk_out_cfg_pkg::DEN_W-1:0]  den_field;

	assign refdiv_code = pll_ref_reg[clk_out_cfg_pkg::REFDIV_LSB +: clk_out_cfg_pkg::CODE_W];
	assign presc_code  = out_lo_reg[clk_out_cfg_pkg::PRESC_LSB +: clk_out_cfg_pkg::CODE_W];
	assign num_field   = out_lo_reg[clk_out_cfg_pkg::NUM_LSB +: clk_out_cfg_pkg::NUM_W];
	assign den_field   = out_den_reg;

	// Reserved ratios fall back to the largest legal division
	assign refdiv_shift = clk_out_cfg_pkg::code_to_shift(refdiv_code,
	                      clk_out_cfg_pkg::REFDIV_MAX_SHIFT);
	assign presc_shift  = clk_out_cfg_pkg::code_to_shift(presc_code,
	                      clk_out_cfg_pkg::PRESC_MAX_SHIFT);

	assign num_eff = (num_field == clk_out_cfg_pkg::NUM_ZERO) ?
	                 clk_out_cfg_pkg::NUM_DEFAULT : num_field;

	// Reference input path

	logic       ref_div_tick;

	pow2_tick_divider #(
		.MAX_SHIFT (3)
	) u_ref_input_divider (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_tick  (i_ref_clock_in_tick),
		.i_shift (refdiv_shift),
		.o_tick  (ref_div_tick)
	);

	// Oscillator takes over in internal mode or with no external clock
	assign internal_ref_next = i_nonsync_internal_mode || !i_ext_clk_detected;
	assign ref_tick_next     = internal_ref_next ? i_osc_tick : ref_div_tick;

	// Sensor reference clock path

	logic       hs_presc_tick;

	pow2_tick_divider #(
		.MAX_SHIFT (4)
	) u_highspeed_prescaler (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_tick  (i_hs_tick),
		.i_shift (presc_shift),
		.o_tick  (hs_presc_tick)
	);

	// Output clock comes from the divider's toggle flop directly
	frac_mn_divider #(
		.M_W (clk_out_cfg_pkg::NUM_W),
		.N_W (clk_out_cfg_pkg::DEN_W)
	) u_frac_divider (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_tick  (hs_presc_tick),
		.i_num   (num_eff),
		.i_den   (den_field),
		.o_clk   (o_sensor_ref_clock_out)
	);

	// State registers

	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			mode_ovr_reg <= clk_out_cfg_pkg::RST_MODE_OVR;
			pll_ref_reg  <= clk_out_cfg_pkg::RST_PLL_REF;
			out_lo_reg   <= clk_out_cfg_pkg::RST_OUT_LO;
			out_den_reg  <= clk_out_cfg_pkg::RST_OUT_DEN;
		end
		else
		begin
			mode_ovr_reg <= mode_ovr_next;
			pll_ref_reg  <= pll_ref_next;
			out_lo_reg   <= out_lo_next;
			out_den_reg  <= out_den_next;
		end
	end

	// Lock already high at reset release counts as a rise
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rx_lock_reg      <= 1'b0;
			rdata_reg        <= clk_out_cfg_pkg::RDATA_NONE;
			internal_ref_reg <= 1'b0;
			ref_tick_reg     <= 1'b0;
		end
		else
		begin
			rx_lock_reg      <= i_rx_lock;
			rdata_reg        <= rdata_next;
			internal_ref_reg <= internal_ref_next;
			ref_tick_reg     <= ref_tick_next;
		end
	end

	// Outputs

	assign o_reg_rdata               = rdata_reg;
	assign o_raw10_compat_mode       = mode_ovr_reg[clk_out_cfg_pkg::RAW10_BIT];
	assign o_raw12_compat_mode       = mode_ovr_reg[clk_out_cfg_pkg::RAW12_BIT];
	assign o_compat_autoload_block   = mode_ovr_reg[clk_out_cfg_pkg::BLOCK_BIT];
	assign o_oscillator_range_select = pll_ref_reg[clk_out_cfg_pkg::OSC_BIT];
	assign o_internal_ref_select     = internal_ref_reg;
	assign o_ref_tick                = ref_tick_reg;

endmodule // clock_output_config

// file: verification/clock_output_config_assertions.sv
/*
 * Port-level checker for clock_output_config.
 * Assumes it is bound to every instance of the block, single i_mclk domain.
 */
`timescale 1ns/1ps
module clock_output_config_assertions (
	input wire logic       i_mclk,
	input wire logic       i_rst_b,
	input wire logic [7:0] i_reg_addr,
	input wire logic       i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic       i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       i_rx_lock,
	input wire logic       i_bc_raw10_mode,
	input wire logic       i_bc_raw12_mode,
	input wire logic       i_osc_tick,
	input wire logic       i_nonsync_internal_mode,
	input wire logic       i_ext_clk_detected,
	input wire logic       o_raw10_compat_mode,
	input wire logic       o_raw12_compat_mode,
	input wire logic       o_compat_autoload_block,
	input wire logic       o_oscillator_range_select,
	input wire logic       o_internal_ref_select,
	input wire logic       o_ref_tick
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_b);

	// Same-cycle writes excluded: they may legally set the block bit
	sequence s_load_rise;
		$rose(i_rx_lock) && !o_compat_autoload_block && !i_reg_wr;
	endsequence
	sequence s_blocked;
		o_compat_autoload_block && !i_reg_wr;
	endsequence

	a_raw10_autoload: assert property (s_load_rise |=> o_raw10_compat_mode == $past(i_bc_raw10_mode))
		else $error("raw10 bit not loaded on lock");
	a_raw12_autoload: assert property (s_load_rise |=> o_raw12_compat_mode == $past(i_bc_raw12_mode))
		else $error("raw12 bit not loaded on lock");
	a_block_holds: assert property (s_blocked |=> $stable({o_raw10_compat_mode, o_raw12_compat_mode}))
		else $error("mode bits changed while blocked");
	a_mode_write: assert property (i_reg_wr && i_reg_addr == 8'h04 && i_reg_wdata[0]
		|=> {o_raw10_compat_mode, o_raw12_compat_mode, o_compat_autoload_block} == $past(i_reg_wdata[2:0]))
		else $error("written mode bits not kept");
	a_osc_range: assert property (i_reg_wr && i_reg_addr == 8'h05
		|=> o_oscillator_range_select == $past(i_reg_wdata[3]))
		else $error("oscillator range select wrong");
	a_internal_ref: assert property ($past(i_rst_b)
		|-> o_internal_ref_select == ($past(i_nonsync_internal_mode) || !$past(i_ext_clk_detected)))
		else $error("internal reference select wrong");
	a_osc_tick_path: assert property ((i_nonsync_internal_mode || !i_ext_clk_detected)
		&& o_internal_ref_select && i_osc_tick |=> o_ref_tick)
		else $error("oscillator tick not passed on");
	a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data changed without a read");
	a_unmapped_read: assert property (i_reg_rd && (i_reg_addr < 8'h04 || i_reg_addr > 8'h07)
		|=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // clock_output_config_assertions

bind clock_output_config clock_output_config_assertions checker_i (.i_mclk, .i_rst_b, .i_reg_addr,
	.i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .i_rx_lock, .i_bc_raw10_mode,
	.i_bc_raw12_mode, .i_osc_tick, .i_nonsync_internal_mode, .i_ext_clk_detected,
	.o_raw10_compat_mode, .o_raw12_compat_mode, .o_compat_autoload_block,
	.o_oscillator_range_select, .o_internal_ref_select, .o_ref_tick);

// file: verification/sensor_clock_model.sv
/*
 * Image sensor side: measures the received reference clock period.
 * Assumes the clock only changes on rising i_mclk edges.
 */
`timescale 1ns/1ps
module sensor_clock_model (
	input  wire logic i_mclk,
	input  wire logic i_sensor_clk,
	output int        o_period
);
	int   count = 0;
	logic last  = 0;

	// Falling edge sampling keeps clear of the launching edge
	always @(negedge i_mclk)
	begin
		count++;
		if (i_sensor_clk && !last)
		begin
			o_period = count;
			count = 0;
		end
		last = i_sensor_clk;
	end
endmodule // sensor_clock_model

// file: verification/clock_output_config_tb.sv
/*
 * Self-checking bench for clock_output_config.
 * Assumes the checker and the sensor model are compiled before it.
 */
`timescale 1ns/1ps
module clock_output_config_tb;
	logic       mclk = 0, rst_b = 0, wr_s = 0, rd_s = 0, lock = 0, b10 = 0, b12 = 0;
	logic       osc = 0, nsync = 0, ext = 1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic       m10, m12, blk, osc_sel, int_sel, ref_tick, sclk;
	int         miscompares = 0, comparisons = 0, cycles = 0, period, ref_gap = 0, gap_cnt = 1;
	logic [7:0] dflt[4] = '{8'h00, 8'h03, 8'h41, 8'h28};
	logic [7:0] pat[4]  = '{8'hF8, 8'hB8, 8'h5E, 8'hC3};
	int         cc[6] = '{0, 1, 2, 4, 0, 3};
	int         mm[6] = '{1, 1, 2, 1, 0, 3};
	int         nn[6] = '{3, 4, 8, 2, 4, 12};
	int         pp[6] = '{3, 8, 16, 32, 4, 32};

	clock_output_config DUT (.i_mclk(mclk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr(wr_s),
		.i_reg_wdata(wdata), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .i_rx_lock(lock),
		.i_bc_raw10_mode(b10), .i_bc_raw12_mode(b12), .i_ref_clock_in_tick(1'b1),
		.i_osc_tick(osc), .i_nonsync_internal_mode(nsync), .i_ext_clk_detected(ext),
		.i_hs_tick(1'b1), .o_raw10_compat_mode(m10), .o_raw12_compat_mode(m12),
		.o_compat_autoload_block(blk), .o_oscillator_range_select(osc_sel),
		.o_internal_ref_select(int_sel), .o_ref_tick(ref_tick), .o_sensor_ref_clock_out(sclk));
	sensor_clock_model sensor (.i_mclk(mclk), .i_sensor_clk(sclk), .o_period(period));

	always #2 mclk = ~mclk;
	always @(posedge mclk) osc <= #1 ~osc;

	// Spacing of reference ticks, 1 means every cycle
	always @(negedge mclk)
	begin
		gap_cnt <= ref_tick ? 1 : gap_cnt + 1;
		if (ref_tick)
			ref_gap <= gap_cnt;
	end

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) #1;
		addr = a;
		wdata = d;
		wr_s = 1;
		@(posedge mclk) #1;
		wr_s = 0;
	endtask

	task rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk) #1;
		addr = a;
		rd_s = 1;
		@(posedge mclk) #1;
		rd_s = 0;
		chk(rdata, e);
	endtask

	task lock_rise(input logic v10, input logic v12);
		@(posedge mclk) #1;
		lock = 0;
		b10 = v10;
		b12 = v12;
		repeat (2) @(posedge mclk);
		#1 lock = 1;
		repeat (2) @(posedge mclk);
	endtask

	task finish_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge mclk);
		#1 rst_b = 1;
		for (int i = 0; i < 4; i++)
			rd_reg(8'h04 + 8'(i), dflt[i]);
		rd_reg(8'h03, 8'h00);
		rd_reg(8'h08, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(8'h04 + 8'(i), pat[i]);
			rd_reg(8'h04 + 8'(i), pat[i]);
		end
		wr_reg(8'h08, 8'hFF);
		rd_reg(8'h07, pat[3]);
		chk(osc_sel, 1'b1);
		$display("test registers done");

		wr_reg(8'h04, 8'h00);
		lock_rise(1'b1, 1'b0);
		rd_reg(8'h04, 8'h04);
		lock_rise(1'b0, 1'b1);
		rd_reg(8'h04, 8'h02);
		wr_reg(8'h04, 8'h05);
		lock_rise(1'b0, 1'b1);
		rd_reg(8'h04, 8'h05);
		chk({m10, m12, blk}, 3'b101);
		$display("test autoload done");

		for (int c = 0; c < 5; c++)
		begin
			wr_reg(8'h05, {1'b0, 3'(c), 4'h3});
			repeat (30) @(posedge mclk);
			chk(ref_gap, (c < 4) ? (1 << c) : 8);
		end
		#1 ext = 0;
		repeat (10) @(posedge mclk);
		chk(int_sel, 1'b1);
		chk(ref_gap, 2);
		#1 ext = 1;
		nsync = 1;
		repeat (3) @(posedge mclk);
		chk(int_sel, 1'b1);
		#1 nsync = 0;
		repeat (3) @(posedge mclk);
		chk(int_sel, 1'b0);
		$display("test reference done");

		for (int i = 0; i < 6; i++)
		begin
			wr_reg(8'h06, {3'(cc[i]), 5'(mm[i])});
			wr_reg(8'h07, 8'(nn[i]));
			repeat (100) @(posedge mclk);
			chk(period, pp[i]);
		end
		$display("test sensor clock done");
		finish_test();
	end
endmodule // clock_output_config_tb
